// ==== verilog/fsp_pkg.sv ====
// Operation
// - Mode 0: data on receive pin, clock on transmit pin
// - Mode 0 shift clock is CPU clock over six
// - Mode 1 frame: start, 8 data, stop
// - Mode 1 stop bit stored as received ninth bit
// - Mode 1 rate from Timer 1 overflow
// - Mode 2 frame: start, 8 data, ninth, stop
// - Mode 2 ninth bit stored, stop value only sets framing error
// - Mode 2 rate CPU clock over 16 or 32
// - Mode 3 like mode 2, Timer 1 rate
// - Any data buffer write starts transmission
// - Mode 0 receives while receive-done clear, enabled
// - Modes 1-3 receive on start bit when enabled
// - Bit 7 shows mode bit or framing error
// - Framing error sticky until software clears it
// - Control register bit layout, mode bits on top
// - Multiprocessor enable suppresses receive-done flag when ninth bit (mode 1: stop bit) clear
// - Transmit-done set by hardware, software clears
// - Double-buffered receive, late byte overwrites first
// - Data buffer write and read are separate
package fsp_pkg;

  // Register byte addresses on the bus
  localparam logic [7:0] OFS_CONTROL_STATUS = 8'h98;
  localparam logic [7:0] OFS_DATA_BUFFER = 8'h9C;
  localparam logic [7:0] OFS_POWER_CONTROL = 8'hA0;
  // Field positions in the power control register
  localparam int BIT_BAUD_DOUBLE = 7;
  localparam int BIT_FE_VIEW = 6;
  // Value after reset of the control register
  localparam logic [7:0] CONTROL_STATUS_RESET = 8'h00;
  // Mode 0 shift clock: six clocks, low half then high half
  localparam logic [2:0] M0_LAST = 3'h5;
  localparam logic [2:0] M0_HALF = 3'h3;
  // Sixteen sample ticks per asynchronous bit
  localparam logic [3:0] DIV_LAST = 4'hF;
  localparam logic [3:0] START_MID = 4'h7;
  // Frame lengths in bit times
  localparam logic [3:0] M0_BITS = 4'h8;
  localparam logic [3:0] M1_BITS = 4'hA;
  localparam logic [3:0] M2_BITS = 4'hB;

  // Mode encoding of the two mode-select bits
  typedef enum logic [1:0] {
    FSP_MODE0 = 2'h0, FSP_MODE1 = 2'h1, FSP_MODE2 = 2'h2, FSP_MODE3 = 2'h3
  } fsp_mode_t;

  // Control register, bit 7 down to bit 0
  typedef struct packed {
    logic mode_select_upper;
    logic mode_select_lower;
    logic multiprocessor_enable;
    logic receive_enable;
    logic transmit_ninth_bit;
    logic received_ninth_bit;
    logic transmit_done_flag;
    logic receive_done_flag;
  } fsp_ctl_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h1, TX_ASYNC = 3'h2, TX_SYNC = 3'h4
  } fsp_tx_t;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1, RX_START = 4'h2, RX_DATA = 4'h4, RX_SYNC = 4'h8
  } fsp_rx_t;

  // Whole state of the serial port core
  typedef struct packed {
    fsp_ctl_t ctl;
    logic fe;
    logic baud_dbl;
    logic fe_view;
    logic [7:0] rx_buf;
    logic ack;
    logic [31:0] rdata;
    fsp_tx_t tx_st;
    logic [10:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [3:0] tx_div;
    fsp_rx_t rx_st;
    logic [9:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [3:0] rx_div;
    logic rx_prev;
    logic [2:0] m0_ph;
    logic txd;
    logic rxd_out;
    logic rxd_oe;
  } fsp_state_t;

  localparam fsp_state_t FSP_STATE_RESET = '{
    ctl: CONTROL_STATUS_RESET, fe: 1'b0, baud_dbl: 1'b0, fe_view: 1'b0,
    rx_buf: 8'h00, ack: 1'b0, rdata: 32'h0000_0000, tx_st: TX_IDLE,
    tx_sh: 11'h7FF, tx_cnt: 4'h0, tx_div: 4'h0, rx_st: RX_IDLE,
    rx_sh: 10'h000, rx_cnt: 4'h0, rx_div: 4'h0, rx_prev: 1'b1,
    m0_ph: 3'h0, txd: 1'b1, rxd_out: 1'b1, rxd_oe: 1'b0};

  // Mode from the two mode-select bits
  function automatic fsp_mode_t fsp_mode(input fsp_ctl_t c);
    return fsp_mode_t'({c.mode_select_upper, c.mode_select_lower});
  endfunction

endpackage

// ==== verilog/fsp_sync.sv ====
`timescale 1ns/1ps
// Two-flop synchroniser for pin inputs
module fsp_sync
  import fsp_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
)(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Asynchronous input and its safe copy
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } fsp_sync_t;

  fsp_sync_t s;
  fsp_sync_t next_s;

  // Only the second stage is visible outside
  always_comb
  begin
    next_s.meta = D;
    next_s.stable = s.meta;
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      s <= '{meta: INIT, stable: INIT};
    else
      s <= next_s;
  end

  assign Q = s.stable;
endmodule

// ==== verilog/fsp_rate.sv ====
`timescale 1ns/1ps
// Sample tick at sixteen times the asynchronous bit rate
module fsp_rate
  import fsp_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Rate selection
  input wire fsp_mode_t MODE,
  input wire logic BAUD_DOUBLE,
  input wire logic TIMER1_OVF,
  // Sample tick, one clock wide
  output logic TICK
);
  typedef struct packed {
    logic half;
    logic tick;
  } fsp_rate_t;

  fsp_rate_t s;
  fsp_rate_t next_s;
  logic event_in;

  // Mode 2 counts clocks, modes 1 and 3 count overflows
  always_comb
  begin
    unique case (MODE)
      FSP_MODE2: event_in = 1'b1;
      FSP_MODE1, FSP_MODE3: event_in = TIMER1_OVF;
      default: event_in = 1'b0;
    endcase
    next_s = s;
    // Without doubling, every second event is dropped
    if (event_in)
      next_s.half = ~s.half;
    next_s.tick = event_in & (BAUD_DOUBLE | s.half);
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      s <= '{half: 1'b0, tick: 1'b0};
    else
      s <= next_s;
  end

  assign TICK = s.tick;
endmodule

// ==== verilog/fsp_core.sv ====
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
// Four-mode serial port with an Avalon-MM register slave
module fsp_core
  import fsp_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Avalon-MM slave
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Bit-rate source for modes 1 and 3
  input wire logic TIMER1_OVF,
  // Serial pins; the receive pin is two-way in mode 0
  input wire logic RXD_IN,
  output logic RXD_OUT,
  output logic RXD_OE,
  output logic TXD
);
  fsp_state_t s; // Current state
  fsp_state_t next_s; // Value for the next edge
  fsp_mode_t mode; // Active mode
  logic tick; // Sample tick, 16 per bit
  logic rx_s; // Synchronised receive pin
  logic wr; // Accepted write, low lane enabled
  logic rd; // Accepted read
  logic [7:0] wd; // Low byte of write data
  logic tx_start; // Data buffer write
  logic m0_active; // Mode 0 shift clock running
  logic [9:0] rx_new; // Receive shift with current sample
  logic stop_bit; // Received stop bit
  logic ninth_bit; // Received ninth bit
  logic [7:0] rx_data; // Received character
  logic accept; // Character passes the address filter

  assign mode = fsp_mode(s.ctl);

  // Pin passes two flops before any logic looks at it
  fsp_sync #(
    .W(1),
    .INIT(1'b1)
  ) u_sync (
    .CLOCK(CLOCK),
    .RST_N(RST_N),
    .D(RXD_IN),
    .Q(rx_s)
  );

  // Sixteen-times sample tick for the asynchronous modes
  fsp_rate u_rate (
    .CLOCK(CLOCK),
    .RST_N(RST_N),
    .MODE(mode),
    .BAUD_DOUBLE(s.baud_dbl),
    .TIMER1_OVF(TIMER1_OVF),
    .TICK(tick)
  );

  // Next-state logic for bus, transmitter and receiver
  always_comb
  begin
    next_s = s;
    wd = AVS_WRITEDATA[7:0];
    // Each request waits one cycle, then completes
    wr = AVS_WRITE & ~s.ack & AVS_BYTEENABLE[0];
    rd = AVS_READ & ~s.ack;
    next_s.ack = (AVS_READ | AVS_WRITE) & ~s.ack;
    tx_start = wr && (AVS_ADDRESS == OFS_DATA_BUFFER);
    m0_active = (s.tx_st == TX_SYNC) || (s.rx_st == RX_SYNC);
    rx_new = {rx_s, s.rx_sh[9:1]};
    stop_bit = rx_new[9];
    ninth_bit = rx_new[8];
    rx_data = rx_new[7:0];
    accept = 1'b1;

    // Read data; unmapped addresses read zero
    if (rd)
    begin
      next_s.rdata = 32'h0000_0000;
      unique case (AVS_ADDRESS)
        OFS_CONTROL_STATUS:
        begin
          next_s.rdata[7:0] = s.ctl;
          // Bit 7 shows the error flag when the view bit is set
          if (s.fe_view)
            next_s.rdata[7] = s.fe;
        end
        OFS_DATA_BUFFER:
          next_s.rdata[7:0] = s.rx_buf;
        OFS_POWER_CONTROL:
        begin
          next_s.rdata[BIT_BAUD_DOUBLE] = s.baud_dbl;
          next_s.rdata[BIT_FE_VIEW] = s.fe_view;
        end
        default:
          next_s.rdata = 32'h0000_0000;
      endcase
    end

    // Software writes come first so hardware sets win below
    if (wr && (AVS_ADDRESS == OFS_CONTROL_STATUS))
    begin
      next_s.ctl = fsp_ctl_t'(wd);
      if (s.fe_view)
      begin
        // Mode bit kept, the write lands on the error flag
        next_s.ctl.mode_select_upper = s.ctl.mode_select_upper;
        next_s.fe = wd[7];
      end
    end
    if (wr && (AVS_ADDRESS == OFS_POWER_CONTROL))
    begin
      next_s.baud_dbl = wd[BIT_BAUD_DOUBLE];
      next_s.fe_view = wd[BIT_FE_VIEW];
    end

    // Mode 0 shift clock phase, six clocks a bit
    if (m0_active)
      next_s.m0_ph = (s.m0_ph == M0_LAST) ? 3'h0 : s.m0_ph + 3'h1;
    else
      next_s.m0_ph = 3'h0;

    // Transmitter
    unique case (s.tx_st)
      TX_IDLE:
        next_s.tx_sh = 11'h7FF;
      TX_ASYNC:
      begin
        if (tick)
        begin
          next_s.tx_div = s.tx_div + 4'h1;
          if (s.tx_div == DIV_LAST)
          begin
            // Bits leave least significant first
            next_s.tx_sh = {1'b1, s.tx_sh[10:1]};
            next_s.tx_cnt = s.tx_cnt - 4'h1;
            // Stop bit begins: flag the transmission done
            if (s.tx_cnt == 4'h2)
              next_s.ctl.transmit_done_flag = 1'b1;
            if (s.tx_cnt == 4'h1)
              next_s.tx_st = TX_IDLE;
          end
        end
      end
      TX_SYNC:
      begin
        if (s.m0_ph == M0_LAST)
        begin
          next_s.tx_sh = {1'b1, s.tx_sh[10:1]};
          next_s.tx_cnt = s.tx_cnt - 4'h1;
          // End of the eighth bit time
          if (s.tx_cnt == 4'h1)
          begin
            next_s.ctl.transmit_done_flag = 1'b1;
            next_s.tx_st = TX_IDLE;
          end
        end
      end
    endcase

    // Any data buffer write restarts the transmitter
    if (tx_start)
    begin
      next_s.tx_div = 4'h0;
      next_s.m0_ph = 3'h0;
      if (mode == FSP_MODE0)
      begin
        next_s.tx_sh = {3'h7, wd};
        next_s.tx_cnt = M0_BITS;
        next_s.tx_st = TX_SYNC;
      end
      else
      begin
        // Mode 1 sends a stop bit in the ninth slot and stops early
        next_s.tx_sh = {1'b1, s.ctl.transmit_ninth_bit | (mode == FSP_MODE1),
                        wd, 1'b0};
        next_s.tx_cnt = (mode == FSP_MODE1) ? M1_BITS : M2_BITS;
        next_s.tx_st = TX_ASYNC;
      end
    end

    // Receiver
    unique case (s.rx_st)
      RX_IDLE:
      begin
        next_s.rx_cnt = 4'h0;
        next_s.rx_div = 4'h0;
        if (mode == FSP_MODE0)
        begin
          // Shift in while the last byte is taken and enabled
          if (!s.ctl.receive_done_flag && s.ctl.receive_enable &&
              s.tx_st == TX_IDLE && !tx_start)
            next_s.rx_st = RX_SYNC;
        end
        else if (s.ctl.receive_enable && s.rx_prev && !rx_s)
          next_s.rx_st = RX_START;
      end
      RX_START:
      begin
        if (tick)
        begin
          next_s.rx_div = s.rx_div + 4'h1;
          // A glitch shorter than half a bit is not a start bit
          if (s.rx_div == START_MID)
          begin
            next_s.rx_div = 4'h0;
            next_s.rx_st = rx_s ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA:
      begin
        if (tick)
        begin
          next_s.rx_div = s.rx_div + 4'h1;
          if (s.rx_div == DIV_LAST)
          begin
            next_s.rx_sh = rx_new;
            next_s.rx_cnt = s.rx_cnt + 4'h1;
            if (s.rx_cnt == ((mode == FSP_MODE1) ? M0_BITS : M0_BITS + 4'h1))
            begin
              next_s.rx_st = RX_IDLE;
              // Mode 1 lands one bit higher in the shift register
              if (mode == FSP_MODE1)
              begin
                rx_data = rx_new[8:1];
                ninth_bit = stop_bit;
                accept = ~s.ctl.multiprocessor_enable | stop_bit;
              end
              else
                accept = ~s.ctl.multiprocessor_enable | ninth_bit;
              // Error flag sticks across characters
              if (!stop_bit)
                next_s.fe = 1'b1;
              // Holding register overwritten if still unread
              if (accept)
              begin
                next_s.rx_buf = rx_data;
                next_s.ctl.received_ninth_bit = ninth_bit;
                next_s.ctl.receive_done_flag = 1'b1;
              end
            end
          end
        end
      end
      RX_SYNC:
      begin
        // Sample on the rising shift clock edge
        if (s.m0_ph == M0_HALF)
        begin
          next_s.rx_sh = rx_new;
          next_s.rx_cnt = s.rx_cnt + 4'h1;
          if (s.rx_cnt == M0_BITS - 4'h1)
          begin
            next_s.rx_buf = rx_new[9:2];
            next_s.ctl.receive_done_flag = 1'b1;
            next_s.rx_st = RX_IDLE;
          end
        end
        // A transmit request takes the shared shift clock
        if (tx_start)
          next_s.rx_st = RX_IDLE;
      end
    endcase
    next_s.rx_prev = rx_s;

    // Pin drivers, registered to keep the pins glitch free
    if (next_s.tx_st == TX_ASYNC)
      next_s.txd = next_s.tx_sh[0];
    else if (next_s.tx_st == TX_SYNC || next_s.rx_st == RX_SYNC)
      next_s.txd = (next_s.m0_ph >= M0_HALF);
    else
      next_s.txd = 1'b1;
    next_s.rxd_oe = (next_s.tx_st == TX_SYNC);
    next_s.rxd_out = next_s.rxd_oe ? next_s.tx_sh[0] : 1'b1;
  end

  // Single state register
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      s <= FSP_STATE_RESET;
    else
      s <= next_s;
  end

  // Outputs
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~s.ack;
  assign AVS_READDATA = s.rdata;
  assign TXD = s.txd;
  assign RXD_OUT = s.rxd_out;
  assign RXD_OE = s.rxd_oe;
endmodule

// ==== verif/fsp_core_props.sv ====
`timescale 1ns/1ps
// Port-level checks of the serial port core
module fsp_core_props
  import fsp_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Register bus
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  // Serial pins
  input wire logic RXD_OE,
  input wire logic TXD
);
  logic wr_buf; // Data buffer write request on the bus
  logic rd_done; // Read completes at this edge
  logic mapped; // Address hits one of the registers
  logic [7:0] since_wr; // Clocks since the last buffer write request
  assign wr_buf = AVS_WRITE && AVS_ADDRESS == OFS_DATA_BUFFER && AVS_BYTEENABLE[0];
  assign rd_done = AVS_READ && !AVS_WAITREQUEST;
  assign mapped = AVS_ADDRESS inside {OFS_CONTROL_STATUS, OFS_DATA_BUFFER, OFS_POWER_CONTROL};
  // Saturating age, so a late drive of the pin is caught without a long window
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      since_wr <= 8'hFF;
    else if (wr_buf)
      since_wr <= 8'h00;
    else if (since_wr != 8'hFF)
      since_wr <= since_wr + 8'h01;
  end
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  AST_WAIT_ONE: assert property (
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("waitrequest high too long");
  AST_RD_UNMAPPED: assert property (
    rd_done && !mapped |-> AVS_READDATA == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_RD_HOLD: assert property (!AVS_READ |=> $stable(AVS_READDATA))
    else $error("read data moved without a read");
  AST_TX_START: assert property (
    wr_buf && !AVS_WAITREQUEST |-> ##[0:6] !TXD)
    else $error("buffer write started nothing");
  AST_CLK_LOW: assert property ($fell(TXD) |-> !TXD [*3])
    else $error("transmit line low too short");
  AST_CLK_HIGH: assert property ($rose(TXD) |-> TXD [*3])
    else $error("transmit line high too short");
  AST_OE_CAUSE: assert property ($rose(RXD_OE) |-> since_wr <= 8'h04)
    else $error("receive pin driven without a write");
  AST_RESET_IDLE: assert property ($rose(RST_N) |-> TXD && !RXD_OE)
    else $error("pins not idle after reset");
  // Main scenarios reached
  cover property (wr_buf && !AVS_WAITREQUEST);
  cover property ($rose(RXD_OE));
  cover property (rd_done && !mapped);
endmodule
bind fsp_core fsp_core_props i_fsp_core_props (.CLOCK(CLOCK), .RST_N(RST_N),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .RXD_OE(RXD_OE), .TXD(TXD));

// ==== verif/fsp_partner.sv ====
`timescale 1ns/1ps
// Far station: async peer and mode 0 shift register
module fsp_partner (
  // Clock
  input wire logic clock,
  // Line levels seen by the station
  input wire logic txd,
  input wire logic rxd_pin,
  // Station drive onto the receive line
  output logic rxd_drv
);
  logic [10:0] got = 11'h7FF; // Last frame taken from the transmit line
  logic [7:0] m0_got; // Byte seen on the receive line in mode 0
  int m0_per; // Shift clock period in ns
  initial rxd_drv = 1'b1;
  // Sends n bits LSB first, bt clocks each, then the line idles high
  task automatic send(input logic [10:0] fr, input int n, input int bt);
    for (int i = 0; i < n; i++)
    begin
      rxd_drv <= fr[i];
      repeat (bt) @(posedge clock);
    end
    rxd_drv <= 1'b1;
  endtask
  // Samples n bits in the middle of each bit time
  task automatic grab(input int n, input int bt);
    @(negedge txd);
    repeat (bt / 2) @(posedge clock);
    for (int i = 0; i < n; i++)
    begin
      got[i] = txd;
      repeat (bt) @(posedge clock);
    end
  endtask
  // Shift register: bit taken and next bit put out on each clock rise
  task automatic m0(input logic [7:0] d);
    time t0;
    rxd_drv <= d[0];
    for (int i = 0; i < 8; i++)
    begin
      @(posedge txd);
      m0_got[i] = rxd_pin;
      if (i == 0)
        t0 = $time;
      if (i == 1)
        m0_per = int'($time - t0);
      // Line is released afterwards, so show the inverse, not a stale level
      if (i < 7)
        rxd_drv <= d[i + 1];
      else
        rxd_drv <= ~d[7];
    end
  endtask
endmodule

// ==== verif/fsp_core_tb_top.sv ====
`timescale 1ns/1ps
// Self-checking bench for the serial port core
module fsp_core_tb_top
  import fsp_pkg::*;
;
  logic clock = 1'b0; // Core clock, 200 MHz
  logic rst_n = 1'b0; // Synchronous reset
  logic [7:0] avs_address = 8'h00; // Bus request
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata; // Bus answer
  logic avs_waitrequest;
  logic timer1_ovf = 1'b0; // Overflow pulse, one clock in three
  logic [1:0] ovf_cnt = 2'h0;
  logic rxd_out; // Shared receive line and its drivers
  logic rxd_oe;
  logic rxd_drv;
  logic rxd_pin;
  logic txd;
  int miscompares = 0;
  int tests_run = 0;
  logic [31:0] rd; // Last word read
  always #2.5 clock = ~clock;
  // Port wins the line while it drives it
  assign rxd_pin = rxd_oe ? rxd_out : rxd_drv;
  // Overflow source for the variable-rate modes
  always @(posedge clock)
  begin
    ovf_cnt <= (ovf_cnt == 2'h2) ? 2'h0 : ovf_cnt + 2'h1;
    timer1_ovf <= (ovf_cnt == 2'h2);
  end
  fsp_core i_fsp_core (.CLOCK(clock), .RST_N(rst_n), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .TIMER1_OVF(timer1_ovf), .RXD_IN(rxd_pin),
    .RXD_OUT(rxd_out), .RXD_OE(rxd_oe), .TXD(txd));
  fsp_partner i_fsp_partner (.clock(clock), .txd(txd), .rxd_pin(rxd_pin),
    .rxd_drv(rxd_drv));
  // Compares and counts one value
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      miscompares++;
    end
  endtask
  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
    input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= ~w;
    do
      @(posedge clock);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 4'hF);
    chk(rd, {24'h000000, exp});
  endtask
  // Reset values, refused lane, unmapped space, field round trip
  task automatic s_regs();
    rchk(OFS_CONTROL_STATUS, CONTROL_STATUS_RESET);
    rchk(OFS_POWER_CONTROL, 8'h00);
    bus(1'b1, OFS_CONTROL_STATUS, 8'hF8, 4'hE);
    rchk(OFS_CONTROL_STATUS, 8'h00);
    wr(8'h10, 8'hFF);
    rchk(8'h10, 8'h00);
    wr(OFS_CONTROL_STATUS, 8'hE8);
    rchk(OFS_CONTROL_STATUS, 8'hE8);
  endtask
  // Full duplex in one async mode: d goes out, ~d comes in
  task automatic s_async(input logic [1:0] m, input logic dbl, input int bt,
    input logic [7:0] d, input logic tb8);
    int n;
    logic [7:0] ctl;
    n = (m == 2'h1) ? 10 : 11;
    ctl = {m, 2'h1, tb8, 3'h0};
    wr(OFS_POWER_CONTROL, {dbl, 7'h00});
    wr(OFS_CONTROL_STATUS, ctl);
    fork
      i_fsp_partner.grab(n, bt);
      i_fsp_partner.send({2'h3, ~d, 1'b0}, n, bt);
      wr(OFS_DATA_BUFFER, d);
    join
    chk(i_fsp_partner.got, {1'b1, (m == 2'h1) | tb8, d, 1'b0});
    rchk(OFS_CONTROL_STATUS, ctl | 8'h07);
    rchk(OFS_DATA_BUFFER, ~d);
    wr(OFS_CONTROL_STATUS, ctl);
    rchk(OFS_CONTROL_STATUS, ctl);
  endtask
  // Receiver off, framing error, address filter, overrun
  task automatic s_errors();
    // Mode bits are set while bit 7 still reaches them, then the error view is opened
    wr(OFS_POWER_CONTROL, 8'h80);
    wr(OFS_CONTROL_STATUS, 8'h80);
    wr(OFS_POWER_CONTROL, 8'hC0);
    i_fsp_partner.send({2'h3, 8'h11, 1'b0}, 11, 16);
    rchk(OFS_CONTROL_STATUS, 8'h00);
    wr(OFS_CONTROL_STATUS, 8'h30);
    i_fsp_partner.send({2'h0, 8'h22, 1'b0}, 11, 16);
    rchk(OFS_CONTROL_STATUS, 8'hB0);
    i_fsp_partner.send({2'h3, 8'h44, 1'b0}, 11, 16);
    i_fsp_partner.send({2'h3, 8'h66, 1'b0}, 11, 16);
    rchk(OFS_CONTROL_STATUS, 8'hB5);
    rchk(OFS_DATA_BUFFER, 8'h66);
    wr(OFS_CONTROL_STATUS, 8'h30);
    rchk(OFS_CONTROL_STATUS, 8'h30);
    wr(OFS_POWER_CONTROL, 8'h80);
    rchk(OFS_CONTROL_STATUS, 8'hB0);
  endtask
  // Shift register mode, out then in
  task automatic s_mode0();
    wr(OFS_CONTROL_STATUS, 8'h00);
    fork
      i_fsp_partner.m0(8'h00);
      wr(OFS_DATA_BUFFER, 8'h96);
    join
    chk(i_fsp_partner.m0_got, 32'h0000_0096);
    chk(i_fsp_partner.m0_per, 32'h0000_001E);
    // Flags land only after the last shift period ends
    repeat (6) @(posedge clock);
    rchk(OFS_CONTROL_STATUS, 8'h02);
    fork
      i_fsp_partner.m0(8'h5A);
      wr(OFS_CONTROL_STATUS, 8'h10);
    join
    repeat (6) @(posedge clock);
    rchk(OFS_CONTROL_STATUS, 8'h11);
    rchk(OFS_DATA_BUFFER, 8'h5A);
  endtask
  // Verdict and end of run
  task automatic report_and_stop();
    if (miscompares == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    s_regs();
    s_async(2'h2, 1'b1, 16, 8'hA5, 1'b1);
    s_async(2'h2, 1'b0, 32, 8'h3C, 1'b0);
    s_async(2'h3, 1'b1, 48, 8'h81, 1'b0);
    s_async(2'h1, 1'b0, 96, 8'h5E, 1'b0);
    s_errors();
    s_mode0();
    report_and_stop();
  end
  // Watchdog, well above the few thousand clocks the tests need
  initial
  begin
    repeat (20000) @(posedge clock);
    miscompares++;
    report_and_stop();
  end
endmodule
